/* design/sat_io_pkg.sv */
// Shared constants and types for the satellite I/O strobe and handshake block.
// Assumes a 10 MHz core clock and an AXI4-Lite register bus with 32-bit data.
package sat_io_pkg;

  // Clock and bit period timing
  localparam int unsigned CLK_PERIOD_PS = 100_000;
  localparam int unsigned BIT_PERIOD_PS = 666_670;     // Slowest network rate
  localparam logic [7:0]  BIT_CYCLES_RST = 8'(BIT_PERIOD_PS / CLK_PERIOD_PS);

  // Widths
  localparam int unsigned IO_W    = 16;
  localparam int unsigned ADDR_W  = 6;
  localparam int unsigned CMD_W   = 4;
  localparam int unsigned SYNC_W  = IO_W + ADDR_W + 2;

  // Command codes that request the basic function
  localparam logic [3:0] CMD_BASIC_A = 4'h0;
  localparam logic [3:0] CMD_BASIC_B = 4'h8;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] OUTWORD_OFS = 8'h08;
  localparam logic [7:0] INWORD_OFS  = 8'h0C;
  localparam logic [7:0] COUNT_OFS   = 8'h10;

  // Status field positions
  localparam int unsigned STAT_ORDER_BIT = 8;
  localparam int unsigned STAT_HS_BIT    = 9;
  localparam int unsigned STAT_BUSY_BIT  = 10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {S_IDLE, S_FIRST, S_GAP, S_SECOND, S_RESP} seq_t;

endpackage : sat_io_pkg

/* design/sat_io_sync.sv */
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
module sat_io_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign pinSync = stage2_reg;

endmodule : sat_io_sync

/* design/sat_io_strobe.sv */
// Strobe and handshake logic of a network satellite I/O device, with AXI4-Lite registers.
// Assumes an upstream receiver hands over each correctly received command packet
// as a one-cycle pulse on the core clock, and a transmitter takes the response word.
//
// What this block does
// - Self-addressed packet data drives parallel outputs.
// - Update strobe pulses; outputs change mid-pulse.
// - Update strobe regardless of command code.
// - Update strobe even when word unchanged.
// - Codes 0 or 8 sample sixteen inputs.
// - Sample strobe pulses; inputs captured mid-pulse.
// - Order select low samples first, high updates first.
// - Handshake enabled while handshake select low.
// - Packet tells whether last response arrived.
// - Handshake on: sample only after good response.
// - Handshake on, bad response: resend old word.
// - Handshake off: codes 0 or 8 always sample afresh.
// - Handshake on, other codes: no sample strobe.
// - Address must equal address-set pins value.
// - Strobes high for two bit periods.
// - Other codes send zero input data.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sat_io_strobe (
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // Decoded command packet from the receiver
  input  wire logic                            pktValid,
  input  wire logic [sat_io_pkg::ADDR_W-1:0]   pktAddr,
  input  wire logic [sat_io_pkg::CMD_W-1:0]    pktCmd,
  input  wire logic [sat_io_pkg::IO_W-1:0]     pktData,
  input  wire logic                            pktPrevRespOk,
  output logic                                 pktBusy,
  // Response word to the transmitter
  output logic                                 respValid,
  output logic [sat_io_pkg::IO_W-1:0]          respData,
  // Pins
  input  wire logic [sat_io_pkg::ADDR_W-1:0]   addressSetPins,
  input  wire logic                            strobeOrderSelect,
  input  wire logic                            handshakeSelect,
  input  wire logic [sat_io_pkg::IO_W-1:0]     parallelInPins,
  output logic [sat_io_pkg::IO_W-1:0]          parallelOutPins,
  output logic                                 outputUpdateStrobe,
  output logic                                 inputSampleStrobe,
  // AXI4-Lite slave
  input  wire logic [7:0]                      s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [7:0]                      s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready
);

  import sat_io_pkg::*;

  typedef struct packed {
    seq_t        st;
    logic [8:0]  cnt;
    logic [7:0]  bitCycles;
    logic [15:0] pendData;
    logic        basicCmd;
    logic        doSample;
    logic        firstIsSample;
    logic [15:0] outWord;
    logic [15:0] inWord;
    logic        outStb;
    logic        inStb;
    logic        busy;
    logic        respValid;
    logic [15:0] respData;
    logic [15:0] updCount;
    logic [15:0] smpCount;
    logic        awReady;
    logic        wReady;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  logic [SYNC_W-1:0] pinSync;
  logic [IO_W-1:0]   inSync;
  logic [ADDR_W-1:0] satAddr;
  logic              orderSync;
  logic              hsSync;

  // Pin levels cross into the core clock
  sat_io_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    ({handshakeSelect, strobeOrderSelect, addressSetPins, parallelInPins}),
    .pinSync  (pinSync)
  );

  assign inSync    = pinSync[IO_W-1:0];
  assign satAddr   = pinSync[IO_W+ADDR_W-1:IO_W];
  assign orderSync = pinSync[IO_W+ADDR_W];
  assign hsSync    = pinSync[IO_W+ADDR_W+1];

  // Next-state logic for sequencer and register bus
  always_comb begin
    logic [8:0]  bc;
    logic [8:0]  halfEnd;
    logic [8:0]  fullEnd;
    logic        basic;
    logic        hsOn;
    logic        midAct;
    logic        wrAddrOk;
    logic [31:0] rdVal;
    logic        rdOk;
    bc       = 9'd0;
    halfEnd  = 9'd0;
    fullEnd  = 9'd0;
    basic    = 1'b0;
    hsOn     = 1'b0;
    midAct   = 1'b0;
    wrAddrOk = 1'b0;
    rdVal    = 32'h0000_0000;
    rdOk     = 1'b0;
    cur_next = cur_reg;
    cur_next.respValid = 1'b0;

    // Effective bit period, never below one cycle
    bc = (cur_reg.bitCycles == 8'h00) ? 9'd1 : {1'b0, cur_reg.bitCycles};
    halfEnd = bc - 9'd1;
    fullEnd = 9'((bc << 1) - 9'd1);

    unique case (cur_reg.st)
      S_IDLE: begin
        // Packets offered while busy are dropped, never queued
        // address match against pins
        if (pktValid && (pktAddr == satAddr)) begin
          basic = (pktCmd == CMD_BASIC_A) || (pktCmd == CMD_BASIC_B);
          hsOn = !hsSync;
          cur_next.basicCmd = basic;
          // previous response status / sampling decision
          cur_next.doSample = basic && (!hsOn || pktPrevRespOk);
          cur_next.firstIsSample = !orderSync && basic && (!hsOn || pktPrevRespOk);
          cur_next.pendData = pktData;
          cur_next.cnt = 9'd0;
          cur_next.st = S_FIRST;
        end
      end
      S_FIRST, S_SECOND: begin
        midAct = (cur_reg.cnt == halfEnd);
        if (midAct) begin
          if ((cur_reg.st == S_FIRST) == cur_reg.firstIsSample) begin
            cur_next.inWord = inSync;
            cur_next.smpCount = cur_reg.smpCount + 16'h0001;
          end else begin
            cur_next.outWord = cur_reg.pendData;
            cur_next.updCount = cur_reg.updCount + 16'h0001;
          end
        end
        if (cur_reg.cnt == fullEnd) begin
          cur_next.cnt = 9'd0;
          // one strobe of each kind at most
          if (cur_reg.st == S_FIRST && (cur_reg.firstIsSample || cur_reg.doSample)) begin
            cur_next.st = S_GAP;
          end else begin
            cur_next.st = S_RESP;
          end
        end else begin
          cur_next.cnt = cur_reg.cnt + 9'd1;
        end
      end
      S_GAP: begin
        if (cur_reg.cnt == halfEnd) begin
          cur_next.cnt = 9'd0;
          cur_next.st = S_SECOND;
        end else begin
          cur_next.cnt = cur_reg.cnt + 9'd1;
        end
      end
      S_RESP: begin
        cur_next.respValid = 1'b1;
        // held word resent / zero for other codes
        cur_next.respData = cur_reg.basicCmd ? cur_reg.inWord : WORD_RST;
        cur_next.st = S_IDLE;
      end
    endcase

    // update strobe in every packet's update phase
    cur_next.outStb = ((cur_next.st == S_FIRST) && !cur_next.firstIsSample) ||
                      ((cur_next.st == S_SECOND) && cur_next.firstIsSample);
    cur_next.inStb  = ((cur_next.st == S_FIRST) && cur_next.firstIsSample) ||
                      ((cur_next.st == S_SECOND) && !cur_next.firstIsSample);
    cur_next.busy   = (cur_next.st != S_IDLE);

    // Only the control register is writable; other offsets answer with an error
    // Write address and data taken in either order
    if (s_axi_awvalid && cur_reg.awReady) begin
      cur_next.awAddr = s_axi_awaddr;
      cur_next.awReady = 1'b0;
    end
    if (s_axi_wvalid && cur_reg.wReady) begin
      cur_next.wData = s_axi_wdata;
      cur_next.wStrb = s_axi_wstrb;
      cur_next.wReady = 1'b0;
    end
    // Write performed once both halves are held
    if (!cur_reg.awReady && !cur_reg.wReady && !cur_reg.bValid) begin
      wrAddrOk = (cur_reg.awAddr == CTRL_OFS);
      if (wrAddrOk && cur_reg.wStrb[0]) begin
        cur_next.bitCycles = cur_reg.wData[7:0];
      end
      cur_next.bValid = 1'b1;
      cur_next.bResp = wrAddrOk ? RESP_OKAY : RESP_SLVERR;
    end
    if (cur_reg.bValid && s_axi_bready) begin
      cur_next.bValid = 1'b0;
      cur_next.awReady = 1'b1;
      cur_next.wReady = 1'b1;
    end

    // Read decode
    if (s_axi_arvalid && cur_reg.arReady) begin
      rdOk = 1'b1;
      unique case (s_axi_araddr)
        CTRL_OFS:    rdVal = {24'h00_0000, cur_reg.bitCycles};
        STATUS_OFS: begin
          rdVal = {26'h000_0000, satAddr};
          rdVal[STAT_ORDER_BIT] = orderSync;
          rdVal[STAT_HS_BIT] = hsSync;
          rdVal[STAT_BUSY_BIT] = cur_reg.busy;
        end
        OUTWORD_OFS: rdVal = {16'h0000, cur_reg.outWord};
        INWORD_OFS:  rdVal = {16'h0000, cur_reg.inWord};
        COUNT_OFS:   rdVal = {cur_reg.smpCount, cur_reg.updCount};
        default:     rdOk = 1'b0;
      endcase
      cur_next.rData = rdVal;
      cur_next.rResp = rdOk ? RESP_OKAY : RESP_SLVERR;
      cur_next.rValid = 1'b1;
      cur_next.arReady = 1'b0;
    end
    if (cur_reg.rValid && s_axi_rready) begin
      cur_next.rValid = 1'b0;
      cur_next.arReady = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur_reg <= '{
        st: S_IDLE, cnt: 9'd0, bitCycles: BIT_CYCLES_RST, pendData: WORD_RST,
        basicCmd: 1'b0, doSample: 1'b0, firstIsSample: 1'b0,
        outWord: WORD_RST, inWord: WORD_RST, outStb: 1'b0, inStb: 1'b0,
        busy: 1'b0, respValid: 1'b0, respData: WORD_RST,
        updCount: 16'h0000, smpCount: 16'h0000,
        awReady: 1'b1, wReady: 1'b1, awAddr: 8'h00, wData: 32'h0000_0000,
        wStrb: 4'h0, bValid: 1'b0, bResp: RESP_OKAY, arReady: 1'b1,
        rValid: 1'b0, rData: 32'h0000_0000, rResp: RESP_OKAY
      };
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs straight from state flops
  assign pktBusy            = cur_reg.busy;
  assign respValid          = cur_reg.respValid;
  assign respData           = cur_reg.respData;
  assign parallelOutPins    = cur_reg.outWord;
  assign outputUpdateStrobe = cur_reg.outStb;
  assign inputSampleStrobe  = cur_reg.inStb;
  assign s_axi_awready      = cur_reg.awReady;
  assign s_axi_wready       = cur_reg.wReady;
  assign s_axi_bvalid       = cur_reg.bValid;
  assign s_axi_bresp        = cur_reg.bResp;
  assign s_axi_arready      = cur_reg.arReady;
  assign s_axi_rvalid       = cur_reg.rValid;
  assign s_axi_rdata        = cur_reg.rData;
  assign s_axi_rresp        = cur_reg.rResp;

endmodule : sat_io_strobe

/* testbench/sat_io_strobe_chk.sv */
// Assertions on packet take, strobes and answer.
// Assumes pins steady three cycles before a packet.
`timescale 1ns/1ps
module sat_io_strobe_chk (
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  input  wire logic                            pktValid,
  input  wire logic                            pktPrevRespOk,
  input  wire logic                            pktBusy,
  input  wire logic                            respValid,
  input  wire logic                            strobeOrderSelect,
  input  wire logic                            handshakeSelect,
  input  wire logic                            outputUpdateStrobe,
  input  wire logic                            inputSampleStrobe,
  input  wire logic [sat_io_pkg::ADDR_W-1:0]   pktAddr,
  input  wire logic [sat_io_pkg::ADDR_W-1:0]   addressSetPins,
  input  wire logic [sat_io_pkg::CMD_W-1:0]    pktCmd,
  input  wire logic [sat_io_pkg::IO_W-1:0]     respData,
  input  wire logic [sat_io_pkg::IO_W-1:0]     parallelOutPins
);
  import sat_io_pkg::*;
  logic take, basic, canSamp, okReg, basReg, updSeen;
  // Packet taken and what it asks for
  assign take = pktValid && !pktBusy && pktAddr == addressSetPins;
  assign basic = pktCmd == CMD_BASIC_A || pktCmd == CMD_BASIC_B;
  assign canSamp = basic && (handshakeSelect || pktPrevRespOk);
  // Hold the taken packet's rights; note an update ran
  always_ff @(posedge core_clk) begin
    if (reset)
      {okReg, basReg, updSeen} <= 3'h0;
    else if (take)
      {okReg, basReg, updSeen} <= {canSamp, basic, 1'h0};
    else if (outputUpdateStrobe)
      updSeen <= 1'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_take; take |=> pktBusy; endproperty
  a_take: assert property (p_take) else $error("packet not taken");
  property p_upd; take && (strobeOrderSelect || !canSamp) |=> outputUpdateStrobe; endproperty
  a_upd: assert property (p_upd) else $error("update strobe late");
  property p_smp;
    take && !strobeOrderSelect && canSamp |=> inputSampleStrobe && !outputUpdateStrobe;
  endproperty
  a_smp: assert property (p_smp) else $error("sample strobe late");
  property p_gate; $rose(inputSampleStrobe) |-> okReg; endproperty
  a_gate: assert property (p_gate) else $error("sample not allowed");
  property p_zero; respValid && !basReg |-> respData == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("input data sent");
  property p_mid;
    $changed(parallelOutPins) |-> outputUpdateStrobe && $past(outputUpdateStrobe);
  endproperty
  a_mid: assert property (p_mid) else $error("outputs moved off strobe");
  property p_once; $rose(outputUpdateStrobe) |-> !updSeen; endproperty
  a_once: assert property (p_once) else $error("second update strobe");
  property p_end;
    respValid |-> $past(pktBusy) && !pktBusy && !outputUpdateStrobe && !inputSampleStrobe;
  endproperty
  a_end: assert property (p_end) else $error("answer before strobes end");
endmodule : sat_io_strobe_chk
bind sat_io_strobe sat_io_strobe_chk chk (.*);

/* testbench/sat_ctrl_model.sv */
// Network controller model: sends command packets, collects answers.
// Assumes an answer within a hundred cycles.
`timescale 1ns/1ps
module sat_ctrl_model (
  input  wire logic                            core_clk,
  input  wire logic                            respValid,
  input  wire logic [sat_io_pkg::IO_W-1:0]     respData,
  output logic                                 pktValid,
  output logic                                 pktPrevRespOk,
  output logic [sat_io_pkg::ADDR_W-1:0]        pktAddr,
  output logic [sat_io_pkg::CMD_W-1:0]         pktCmd,
  output logic [sat_io_pkg::IO_W-1:0]          pktData
);
  import sat_io_pkg::*;
  initial {pktValid, pktPrevRespOk, pktAddr, pktCmd, pktData} = 28'h000_0000;
  // One packet pulse; stale payload inverted
  task automatic send(input logic [5:0] a, input logic [3:0] c, input logic [15:0] d,
                      input logic ok, output logic got, output logic [15:0] r);
    got = 1'h0;
    @(posedge core_clk);
    {pktValid, pktPrevRespOk, pktAddr, pktCmd, pktData} <= {1'h1, ok, a, c, d};
    @(posedge core_clk);
    {pktValid, pktPrevRespOk, pktAddr, pktCmd, pktData} <= {1'h0, ~ok, ~a, ~c, ~d};
    for (int n = 0; n < 100 && got !== 1'h1; n++) begin
      @(negedge core_clk);
      got = respValid;
      r = respData;
    end
  endtask : send
endmodule : sat_ctrl_model

/* testbench/sat_io_strobe_tb.sv */
// Testbench: packets through the controller model, registers over AXI4-Lite.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
module sat_io_strobe_tb;
  import sat_io_pkg::*;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic pktValid, pktPrevRespOk, pktBusy, respValid, got;
  logic strobeOrderSelect, handshakeSelect, outputUpdateStrobe, inputSampleStrobe;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] pktAddr, addressSetPins;
  logic [3:0] pktCmd;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] pktData, respData, parallelInPins, parallelOutPins, r;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  int fail_count = 0;
  int n_compared = 0;
  int hU, hS, bp;
  // Clock and instances
  always #50 core_clk = ~core_clk;
  sat_io_strobe dut (.*);
  sat_ctrl_model ctl (.*);
  // High cycles of each strobe
  always @(negedge core_clk) begin
    hU += int'(outputUpdateStrobe);
    hS += int'(inputSampleStrobe);
  end
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // A wait that ran out ends the run
  task automatic must(input logic ok);
    if (ok !== 1'h1) begin
      fail_count++;
      complete_run();
    end
  endtask : must
  // One register write or read; each channel held until taken
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic tA, tW, tR, done;
    done = 1'h0;
    @(posedge core_clk);
    if (wr)
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (int n = 0; n < 50 && done !== 1'h1; n++) begin
      @(negedge core_clk);
      {tA, tW, tR} = {s_axi_awready, s_axi_wready, s_axi_arready};
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      v = s_axi_rdata;
      @(posedge core_clk);
      s_axi_awvalid <= s_axi_awvalid & ~tA;
      s_axi_wvalid <= s_axi_wvalid & ~tW;
      s_axi_arvalid <= s_axi_arvalid & ~tR;
      if (done === 1'h1)
        {s_axi_bready, s_axi_rready} <= 2'h0;
    end
    must(done);
  endtask : axi
  // One own packet: answer, outputs and strobe widths
  task automatic pkt(input logic [3:0] c, input logic [15:0] d, input logic [15:0] din,
                     input logic ok, input logic smp, input logic [15:0] er);
    parallelInPins <= din;
    repeat (4) @(posedge core_clk);
    hU = 0;
    hS = 0;
    ctl.send(addressSetPins, c, d, ok, got, r);
    must(got);
    check(er, r);
    check(d, parallelOutPins);
    check(2 * bp, hU);
    check(2 * bp * smp, hS);
  endtask : pkt
  // Reset, then scenarios
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    {addressSetPins, strobeOrderSelect, parallelInPins} = 23'h2A_0000;
    handshakeSelect = 1'h1;
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    axi(1'h0, CTRL_OFS, 32'h0000_0000);
    check(32'h0000_0006, v);
    axi(1'h1, CTRL_OFS, 32'h0000_0001);
    check(RESP_OKAY, rs);
    bp = 1;
    axi(1'h0, 8'h14, 32'h0000_0000);
    check(RESP_SLVERR, rs);
    // Every code, handshake off, last answer lost
    for (int i = 0; i < 16; i++)
      pkt(4'(i), {4'(i), 12'h5A3}, {12'hC3A, 4'(i)}, 1'h0, i % 8 == 0,
          i % 8 == 0 ? {12'hC3A, 4'(i)} : 16'h0000);
    pkt(4'h5, 16'hF5A3, 16'h0000, 1'h1, 1'h0, 16'h0000);
    strobeOrderSelect <= 1'h1;
    pkt(4'h8, 16'h0F0F, 16'hBEEF, 1'h1, 1'h1, 16'hBEEF);
    // Handshake on: fresh, held, other code
    {strobeOrderSelect, handshakeSelect} <= 2'h0;
    pkt(4'h0, 16'h1111, 16'h1234, 1'h1, 1'h1, 16'h1234);
    pkt(4'h8, 16'h2222, 16'h5678, 1'h0, 1'h0, 16'h1234);
    pkt(4'h3, 16'h3333, 16'h9ABC, 1'h1, 1'h0, 16'h0000);
    axi(1'h0, INWORD_OFS, 32'h0000_0000);
    check(32'h0000_1234, v);
    axi(1'h0, STATUS_OFS, 32'h0000_0000);
    check(32'h0000_0015, v);
    ctl.send(~addressSetPins, 4'h0, 16'hFFFF, 1'h1, got, r);
    check(1'h0, got);
    check(16'h3333, parallelOutPins);
    axi(1'h1, CTRL_OFS, 32'h0000_0006);
    check(RESP_OKAY, rs);
    bp = 6;
    pkt(4'h8, 16'h4444, 16'h00FF, 1'h1, 1'h1, 16'h00FF);
    // Twenty-two updates and five samples so far, one of each at most per packet
    axi(1'h0, COUNT_OFS, 32'h0000_0000);
    check(32'h0005_0016, v);
    complete_run();
  end
endmodule : sat_io_strobe_tb
